// file: design/tfsc_pkg.sv
`default_nettype none
package tfsc_pkg;

  // State settling delays, in crystal clock cycles
  localparam logic [15:0] SETTLE_NOCAL_CYC = 16'h07A2; // 1954
  localparam logic [15:0] SETTLE_CAL_CYC   = 16'h07A1; // 1953
  localparam logic [15:0] MCAL_SETUP_CYC   = 16'h011B; // 283

  // Short calibration stages, charge pump stage skipped
  localparam logic [15:0] CAL_SHORT_09_CYC = 16'h0EB4; // 3764
  localparam logic [15:0] CAL_SHORT_0B_CYC = 16'h0FE9; // 4073

  // Calibration test settings
  localparam logic [7:0] CAL_TEST_09 = 8'h09;
  localparam logic [7:0] CAL_TEST_0B = 8'h0B;

  // Charge pump calibration field
  localparam logic [1:0] CP_CAL_OFF = 2'h0;
  localparam logic [1:0] CP_CAL_ON  = 2'h2;

  // Automatic calibration choices
  localparam logic [1:0] AUTOCAL_NEVER  = 2'h0;
  localparam logic [1:0] AUTOCAL_TURNON = 2'h1;
  localparam logic [1:0] AUTOCAL_TURNOFF = 2'h2;
  localparam logic [1:0] AUTOCAL_FOURTH = 2'h3;
  localparam logic [1:0] AUTOCAL_LAST   = 2'h3;

  // On-off keying power table selector
  localparam logic [2:0] PWR_SEL_OOK = 3'h1;

  // Output selection codes
  localparam logic [5:0] GPO_SEL_THRESH = 6'h02;
  localparam logic [5:0] GPO_SEL_LOCK   = 6'h0A;

  // Calibration register reads this while unlocked
  localparam logic [5:0] CAL_UNLOCKED = 6'h3F;

  // Serial header fields
  localparam int         HDR_RW_BIT    = 7;
  localparam logic [5:0] FIFO_ADDR     = 6'h3F;
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // Threshold: base minus four per step
  localparam logic [6:0] THR_BASE  = 7'h3D; // 61
  localparam int         THR_SHIFT = 2;
  localparam logic [6:0] FILL_SAT  = 7'h0F;

  // Radio controller states, Gray along the usual path
  typedef enum logic [2:0] {
    TFSC_IDLE   = 3'h0,
    TFSC_SETTLE = 3'h1,
    TFSC_CAL    = 3'h3,
    TFSC_TX     = 3'h2,
    TFSC_TXEND  = 3'h6,
    TFSC_SYNON  = 3'h7,
    TFSC_MCAL   = 3'h5,
    TFSC_SLEEP  = 3'h4
  } tfsc_state_t;

endpackage
`default_nettype wire

// file: design/tfsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module tfsc_top #(
  parameter int DEPTH            = 64,
  parameter int CAL_LONG_09_CYC  = 18506,
  parameter int CAL_LONG_0B_CYC  = 18815,
  parameter int XOSC_START_CYC   = 64,
  parameter logic [5:0] CAL_LOCK_VALUE = 6'h20
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Serial pins
  input  wire logic              sclk_i,
  input  wire logic              mosi_i,
  input  wire logic              chip_select_n_i,
  output var  logic              miso_o,
  output var  logic              miso_oe_o,
  // Command strobes
  input  wire logic              tx_strobe_i,
  input  wire logic              synth_on_strobe_i,
  input  wire logic              idle_strobe_i,
  input  wire logic              calibrate_strobe_i,
  input  wire logic              power_down_strobe_i,
  // Configuration
  input  wire logic [1:0]        auto_cal_select_i,
  input  wire logic [7:0]        cal_test_setting_i,
  input  wire logic [1:0]        charge_pump_cal_enable_i,
  input  wire logic [2:0]        power_table_selector_i,
  input  wire logic [3:0]        fifo_threshold_select_i,
  input  wire logic [15:0]       symbol_period_i,
  input  wire logic [23:0]       carrier_word_i,
  input  wire logic [5:0]        output_signal_select_i,
  // Transmitter side
  input  wire logic              packet_done_i,
  input  wire logic              tx_byte_req_i,
  output var  logic [7:0]        tx_byte_o,
  output var  logic              tx_byte_valid_o,
  output var  logic              underflow_o,
  // Status
  output var  tfsc_pkg::tfsc_state_t radio_state_o,
  output var  logic [6:0]        tx_fill_count_o,
  output var  logic              threshold_flag_o,
  output var  logic              lock_o,
  output var  logic [5:0]        synth_cal_value_o,
  output var  logic              general_purpose_output_o,
  output var  logic [23:0]       carrier_word_o,
  output var  logic              core_power_on_o
);
  import tfsc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // Threshold table and pointer wrap need exactly this depth
  if (DEPTH != 64) begin : g_chk_depth
    $error("tfsc_top: DEPTH must be 64");
  end
  if (CAL_LONG_09_CYC < 1 || CAL_LONG_09_CYC > 65535 ||
      CAL_LONG_0B_CYC < 1 || CAL_LONG_0B_CYC > 65535 ||
      XOSC_START_CYC < 1 || XOSC_START_CYC > 65535) begin : g_chk_cnt
    $error("tfsc_top: cycle counts must fit 16 bits");
  end

  localparam logic [15:0] CAL_LONG_09 = 16'(CAL_LONG_09_CYC);
  localparam logic [15:0] CAL_LONG_0B = 16'(CAL_LONG_0B_CYC);
  localparam logic [15:0] XOSC_START  = 16'(XOSC_START_CYC);

  // Pin synchronisers; stage one is read only by stage two
  logic [2:0] sclk_s;
  logic [1:0] mosi_s;
  logic [2:0] cs_s;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_s <= 3'h0;
      mosi_s <= 2'h0;
      cs_s   <= 3'h7;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      mosi_s <= {mosi_s[0], mosi_i};
      cs_s   <= {cs_s[1:0], chip_select_n_i};
    end
  end

  // Edges seen from the settled stages only
  wire cs_n      = cs_s[1];
  wire cs_rise   = cs_s[1] & ~cs_s[2];
  wire sclk_rise = sclk_s[1] & ~sclk_s[2] & ~cs_n;
  wire sclk_fall = ~sclk_s[1] & sclk_s[2] & ~cs_n;

  tfsc_state_t state;
  tfsc_state_t next_state;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic        cal_req;
  logic        next_cal_req;
  logic        after_idle;
  logic        next_after_idle;
  logic        target_tx;
  logic        next_target_tx;
  logic        pd_pending;
  logic        calibrated;
  logic [1:0]  off_cnt;
  logic [6:0]  count;

  // Calibration length from test setting and charge pump field
  wire cp_on = (charge_pump_cal_enable_i != CP_CAL_OFF);
  wire is_0b = (cal_test_setting_i == CAL_TEST_0B);
  wire [15:0] cal_len = is_0b ? (cp_on ? CAL_LONG_0B : CAL_SHORT_0B_CYC)
                              : (cp_on ? CAL_LONG_09 : CAL_SHORT_09_CYC);

  // Turn-off time: quarter symbol, plus an eighth under on-off keying
  wire        is_ook   = (power_table_selector_i == PWR_SEL_OOK);
  wire [15:0] quarter  = symbol_period_i >> 2;
  wire [15:0] eighth   = is_ook ? (symbol_period_i >> 3) : 16'h0000;
  wire [15:0] end_sum  = quarter + eighth;
  wire [15:0] end_len  = (end_sum == 16'h0000) ? 16'h0001 : end_sum;

  // Calibration choices for turn-on and automatic turn-off
  wire cal_on_turnon = (auto_cal_select_i == AUTOCAL_TURNON);
  wire cal_on_off    = (auto_cal_select_i == AUTOCAL_TURNOFF) ||
                       (auto_cal_select_i == AUTOCAL_FOURTH &&
                        off_cnt == AUTOCAL_LAST);
  wire go_active = tx_strobe_i | synth_on_strobe_i;
  wire tmr_done  = (tmr == 16'h0000);

  // Radio controller sequencing
  always_comb
  begin
    next_state      = state;
    next_tmr        = tmr_done ? tmr : tmr - 16'h0001;
    next_cal_req    = cal_req;
    next_after_idle = after_idle;
    next_target_tx  = target_tx;
    case (state)
      TFSC_IDLE:
        if (pd_pending && cs_rise)
        begin
          next_state = TFSC_SLEEP;
          next_tmr   = XOSC_START - 16'h0001;
        end
        else if (go_active)
        begin
          next_state     = TFSC_SETTLE;
          next_target_tx = tx_strobe_i;
          next_cal_req   = cal_on_turnon;
          next_tmr       = cal_on_turnon ? SETTLE_CAL_CYC - 16'h0001
                                         : SETTLE_NOCAL_CYC - 16'h0001;
        end
        else if (calibrate_strobe_i)
        begin
          next_state = TFSC_MCAL;
          next_tmr   = MCAL_SETUP_CYC - 16'h0001;
        end
      TFSC_SETTLE:
        if (idle_strobe_i)
          next_state = TFSC_IDLE;
        else if (tmr_done && cal_req)
        begin
          next_state      = TFSC_CAL;
          next_after_idle = 1'b0;
          next_tmr        = cal_len - 16'h0001;
        end
        else if (tmr_done)
          next_state = target_tx ? TFSC_TX : TFSC_SYNON;
      TFSC_CAL:
        if (tmr_done && after_idle)
          next_state = TFSC_IDLE;
        else if (tmr_done)
          next_state = target_tx ? TFSC_TX : TFSC_SYNON;
      TFSC_MCAL:
        if (tmr_done)
        begin
          next_state      = TFSC_CAL;
          next_after_idle = 1'b1;
          next_tmr        = cal_len - 16'h0001;
        end
      TFSC_SYNON:
        if (idle_strobe_i)
          next_state = TFSC_IDLE;
        else if (tx_strobe_i)
          next_state = TFSC_TX;
      TFSC_TX:
        if (idle_strobe_i || packet_done_i)
        begin
          next_state   = TFSC_TXEND;
          next_cal_req = ~idle_strobe_i & cal_on_off;
          next_tmr     = end_len - 16'h0001;
        end
      TFSC_TXEND:
        if (tmr_done && cal_req)
        begin
          next_state      = TFSC_CAL;
          next_after_idle = 1'b1;
          next_tmr        = cal_len - 16'h0001;
        end
        else if (tmr_done)
          next_state = TFSC_IDLE;
      TFSC_SLEEP:
        if (cs_n)
          next_tmr = XOSC_START - 16'h0001;
        else if (tmr_done)
          next_state = TFSC_IDLE;
      default:
        next_state = TFSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state      <= TFSC_IDLE;
      tmr        <= 16'h0000;
      cal_req    <= 1'b0;
      after_idle <= 1'b0;
      target_tx  <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      tmr        <= next_tmr;
      cal_req    <= next_cal_req;
      after_idle <= next_after_idle;
      target_tx  <= next_target_tx;
    end
  end

  // Power-down request, every-fourth counter, calibration memory
  wire auto_off = (state == TFSC_TX) & packet_done_i & ~idle_strobe_i;
  wire cal_end  = (state == TFSC_CAL) & tmr_done;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pd_pending <= 1'b0;
      off_cnt    <= 2'h0;
      calibrated <= 1'b0;
    end
    else
    begin
      if (state == TFSC_SLEEP)
        pd_pending <= 1'b0;
      else if (state == TFSC_IDLE && power_down_strobe_i)
        pd_pending <= 1'b1;
      if (auto_off)
        off_cnt <= off_cnt + 2'h1;
      if (cal_end)
        calibrated <= 1'b1; // survives sleep
    end
  end

  // Lock detector model: calibrated and synthesizer running
  wire synth_run = (state == TFSC_SYNON) | (state == TFSC_TX) |
                   (state == TFSC_TXEND);
  wire next_lock = calibrated & synth_run;

  // Serial slave: mode 0, sample on rise, shift on fall
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic       hdr_seen;
  logic       wr_mode;
  wire [7:0]  rx_byte   = {shift_in[6:0], mosi_s[1]};
  wire        byte_done = sclk_rise & (bit_cnt == LAST_BIT);
  wire        hdr_fifo  = ~rx_byte[HDR_RW_BIT] & (rx_byte[5:0] == FIFO_ADDR);
  wire        spi_wr    = byte_done & hdr_seen & wr_mode;
  wire [3:0]  fill4     = (count > FILL_SAT) ? 4'hF : count[3:0];
  wire [7:0]  status    = {state == TFSC_SLEEP, state, fill4};
  wire        load_stat = (bit_cnt == 3'h0) & ~sclk_s[1];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bit_cnt   <= 3'h0;
      shift_in  <= 8'h00;
      shift_out <= 8'h80;
      hdr_seen  <= 1'b0;
      wr_mode   <= 1'b0;
    end
    else if (cs_n)
    begin
      bit_cnt  <= 3'h0;
      hdr_seen <= 1'b0;
      wr_mode  <= 1'b0;
      shift_out <= status;
    end
    else
    begin
      if (sclk_rise)
      begin
        bit_cnt  <= bit_cnt + 3'h1;
        shift_in <= rx_byte;
      end
      if (byte_done && !hdr_seen)
      begin
        hdr_seen <= 1'b1;
        wr_mode  <= hdr_fifo;
      end
      // Reload keeps ready and fill fresh until the first clock edge
      if (load_stat)
        shift_out <= status;
      else if (sclk_fall)
        shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // Transmit FIFO storage and pointers
  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  wire empty = (count == 7'h00);
  wire full  = (count == 7'(DEPTH));
  // Overfill is the host's fault; the byte is dropped here
  wire wr_en = spi_wr & ~full;
  wire rd_en = tx_byte_req_i & ~empty;
  wire underflow_ev = tx_byte_req_i & empty;
  wire [6:0] thr = THR_BASE - {1'b0, fifo_threshold_select_i, 2'b00};
  wire [6:0] next_count = count + {6'h00, wr_en} - {6'h00, rd_en};

  always_ff @(posedge clk_i)
  begin
    if (wr_en)
      mem[wptr] <= rx_byte;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr            <= '0;
      rptr            <= '0;
      count           <= 7'h00;
      tx_byte_o       <= 8'h00;
      tx_byte_valid_o <= 1'b0;
      underflow_o     <= 1'b0;
    end
    else
    begin
      if (wr_en)
        wptr <= wptr + AW'(1);
      if (rd_en)
      begin
        rptr      <= rptr + AW'(1);
        tx_byte_o <= mem[rptr];
      end
      count           <= next_count;
      tx_byte_valid_o <= rd_en;
      // New underflow wins over the clearing strobe
      if (underflow_ev)
        underflow_o <= 1'b1;
      else if (idle_strobe_i)
        underflow_o <= 1'b0;
    end
  end

  // Registered status and pin outputs
  wire gpo_next = (output_signal_select_i == GPO_SEL_LOCK)   ? lock_o :
                  (output_signal_select_i == GPO_SEL_THRESH) ? threshold_flag_o :
                  1'b0;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      miso_o                   <= 1'b1;
      miso_oe_o                <= 1'b0;
      radio_state_o            <= TFSC_IDLE;
      tx_fill_count_o          <= 7'h00;
      threshold_flag_o         <= 1'b0;
      lock_o                   <= 1'b0;
      synth_cal_value_o        <= CAL_UNLOCKED;
      general_purpose_output_o <= 1'b0;
      carrier_word_o           <= 24'h000000;
      core_power_on_o          <= 1'b1;
    end
    else
    begin
      miso_o            <= shift_out[7];
      miso_oe_o         <= ~cs_n;
      radio_state_o     <= state;
      tx_fill_count_o   <= count;
      threshold_flag_o  <= (count >= thr);
      lock_o            <= next_lock;
      synth_cal_value_o <= next_lock ? CAL_LOCK_VALUE : CAL_UNLOCKED;
      general_purpose_output_o <= gpo_next;
      // Word only taken in idle, so the synthesizer never sees a jump
      if (state == TFSC_IDLE)
        carrier_word_o <= carrier_word_i;
      core_power_on_o <= (next_state != TFSC_SLEEP) | ~cs_n;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire leave = (next_state != state);

  // Cycles in the present state; a counter avoids deep sampled history
  logic [15:0] dwell;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dwell <= 16'h0001;
    else if (leave)
      dwell <= 16'h0001;
    else if (dwell != 16'hFFFF)
      dwell <= dwell + 16'h0001;
  end

  a_settle_nocal: assert property (
    state == TFSC_SETTLE && leave && !idle_strobe_i && !cal_req |->
    dwell == SETTLE_NOCAL_CYC)
    else $error("settle without calibration wrong length");
  a_settle_cal: assert property (
    state == TFSC_SETTLE && leave && !idle_strobe_i && cal_req |->
    dwell == SETTLE_CAL_CYC)
    else $error("settle before calibration wrong length");
  a_cal_length: assert property (
    $rose(state == TFSC_CAL) |-> tmr == cal_len - 16'h0001)
    else $error("calibration length wrong");
  a_mcal_setup: assert property (
    state == TFSC_MCAL && leave |-> dwell == MCAL_SETUP_CYC)
    else $error("manual calibration setup wrong length");
  a_txend_len: assert property (
    $rose(state == TFSC_TXEND) |->
    tmr == end_len - 16'h0001 && end_len >= quarter)
    else $error("turn-off length wrong");
  a_underflow_set: assert property (
    tx_byte_req_i && empty |=> underflow_o && !tx_byte_valid_o)
    else $error("underflow not flagged");
  a_fill_up: assert property (
    wr_en && !rd_en |=> count == $past(count) + 7'h01)
    else $error("fill count not incremented");
  a_thresh_flag: assert property (
    1'b1 |=> threshold_flag_o == ($past(count) >= $past(thr)))
    else $error("threshold flag wrong");
  a_lock_output: assert property (
    output_signal_select_i == GPO_SEL_LOCK ##1
    output_signal_select_i == GPO_SEL_LOCK |->
    general_purpose_output_o == $past(lock_o))
    else $error("lock not shown on output");
  a_lock_value: assert property (
    lock_o == (synth_cal_value_o != CAL_UNLOCKED))
    else $error("calibration value disagrees with lock");
  a_sleep_power: assert property (
    state == TFSC_SLEEP && cs_n |=> !core_power_on_o)
    else $error("core powered in sleep");
  a_manual_cal: assert property (
    state == TFSC_IDLE && calibrate_strobe_i && !go_active &&
    !(pd_pending && cs_rise) |=> state == TFSC_MCAL)
    else $error("manual calibration not started");

  c_tx_with_cal: cover property (state == TFSC_CAL && !after_idle &&
    tmr_done);
  c_manual_cal: cover property (state == TFSC_MCAL ##1 state == TFSC_CAL);
  c_fifo_write: cover property (wr_en ##[1:1000] threshold_flag_o);
  c_sleep_wake: cover property (state == TFSC_SLEEP ##[1:1000]
    state == TFSC_IDLE);

endmodule
`default_nettype wire

// file: testbench/tfsc_host.sv
`timescale 1ns/100ps
`default_nettype none
module tfsc_host (
  // Serial pins toward the device
  output var  logic sclk_o,
  output var  logic mosi_o,
  output var  logic chip_select_n_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  localparam int HALF = 80;

  // Idle levels: clock low, not selected
  initial
  begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    chip_select_n_o = 1'b1;
  end

  // Select, then no clock edge before the ready level
  task automatic select_ready();
    int w;
    w = 0;
    #7 chip_select_n_o = 1'b0;
    while (!(miso_oe_i === 1'b1 && miso_i === 1'b0) && w < 400)
    begin
      w++;
      #20;
    end
  endtask

  // Release select; data line stops holding its last bit
  task automatic deselect();
    #HALF chip_select_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask

  // Mode 0 byte, MSB first; sample late in the high phase
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_o = b[i];
      #HALF sclk_o = 1'b1;
      #HALF r[i] = miso_i;
      sclk_o = 1'b0;
    end
  endtask

  // Burst write header, then data; never more than the FIFO holds
  task automatic burst(input logic [7:0] d[$], output logic [7:0] st);
    logic [7:0] junk;
    if (d.size() > 64)
      d = d[0:63];
    select_ready();
    xfer(8'h7F, st);
    foreach (d[i])
      xfer(d[i], junk);
    deselect();
  endtask

  // Select without clocks, used to enter and leave sleep
  task automatic touch();
    select_ready();
    deselect();
  endtask
endmodule
`default_nettype wire

// file: testbench/test_tfsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_tfsc_top;
  import tfsc_pkg::*;
  // Strobe bits: tx, synth, idle, calibrate, power down, packet done
  localparam logic [5:0] S_TX = 6'h01, S_SY = 6'h02, S_ID = 6'h04,
                         S_CA = 6'h08, S_PD = 6'h10, S_PK = 6'h20;
  // Bench drive and design outputs
  logic        clk_i, rst_i, req, sclk, mosi, chip_select_n, miso, moe;
  logic        bval, unf, thf, lock, gpo, pon;
  logic [5:0]  stb, osel, calv;
  logic [1:0]  acal, cpen;
  logic [7:0]  ctest, st, byte_o;
  logic [2:0]  pwr;
  logic [3:0]  thr;
  logic [15:0] per;
  logic [23:0] cw, cwo;
  logic [6:0]  fill;
  tfsc_state_t rs;
  logic [7:0]  exp_q[$];
  int          errors, tests_run, n;
  int          cal_len[4] = '{3764, 50, 4073, 60};

  tfsc_host host (.sclk_o(sclk), .mosi_o(mosi),
                  .chip_select_n_o(chip_select_n), .miso_i(miso),
                  .miso_oe_i(moe));
  tfsc_top #(.CAL_LONG_09_CYC(50), .CAL_LONG_0B_CYC(60), .XOSC_START_CYC(4))
  dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .mosi_i(mosi),
    .chip_select_n_i(chip_select_n), .miso_o(miso), .miso_oe_o(moe),
    .tx_strobe_i(stb[0]), .synth_on_strobe_i(stb[1]), .idle_strobe_i(stb[2]),
    .calibrate_strobe_i(stb[3]), .power_down_strobe_i(stb[4]),
    .auto_cal_select_i(acal), .cal_test_setting_i(ctest),
    .charge_pump_cal_enable_i(cpen), .power_table_selector_i(pwr),
    .fifo_threshold_select_i(thr), .symbol_period_i(per),
    .carrier_word_i(cw), .output_signal_select_i(osel),
    .packet_done_i(stb[5]), .tx_byte_req_i(req), .tx_byte_o(byte_o),
    .tx_byte_valid_o(bval), .underflow_o(unf), .radio_state_o(rs),
    .tx_fill_count_o(fill), .threshold_flag_o(thf), .lock_o(lock),
    .synth_cal_value_o(calv), .general_purpose_output_o(gpo),
    .carrier_word_o(cwo), .core_power_on_o(pon));

  // Clock at 50 MHz
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // Compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %0h, wanted %0h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got);
    tests_run++;
    if (exp_q.size() == 0 || got !== exp_q[0])
    begin
      errors++;
      $display("unexpected at %0t: popped byte %0h", $time, got);
    end
    if (exp_q.size() > 0)
      void'(exp_q.pop_front());
  endtask

  // One-cycle strobe, driven at the falling edge
  task automatic pulse(input logic [5:0] m);
    stb = m;
    @(negedge clk_i);
    stb = '0;
  endtask

  // Cycles that the reported state holds a value
  task automatic measure(input tfsc_state_t s, output int c);
    int w;
    w = 0;
    c = 0;
    while (rs !== s && w < 40000)
    begin
      w++;
      @(negedge clk_i);
    end
    while (rs === s && c < 40000)
    begin
      c++;
      @(negedge clk_i);
    end
  endtask

  // Host writes n random bytes; each is noted for the pop side
  task automatic fill_n(input int k, output logic [7:0] s);
    logic [7:0] d[$];
    logic [7:0] b;
    for (int i = 0; i < k; i++)
    begin
      b = 8'($urandom);
      d.push_back(b);
      exp_q.push_back(b);
    end
    host.burst(d, s);
    repeat (8) @(negedge clk_i);
  endtask

  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Popped bytes against the oldest note
  always @(negedge clk_i)
    if (bval === 1'b1)
      chk_byte(byte_o);

  // Watchdog well above the expected run of about 35000 cycles
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h1A17));
    rst_i = 1'b1;
    stb = '0;
    req = 1'b0;
    acal = AUTOCAL_NEVER;
    ctest = CAL_TEST_09;
    cpen = CP_CAL_OFF;
    pwr = 3'h0;
    thr = 4'hE;
    per = 16'h0020 + 16'($urandom % 64);
    cw = 24'($urandom);
    osel = GPO_SEL_THRESH;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    chk(32'({rs, calv, pon, fill}), 32'({TFSC_IDLE, CAL_UNLOCKED, 8'h80}));
    fill_n(4, st);
    chk(32'({st, fill, thf, gpo}), 32'({8'h00, 7'h04, 2'b00}));
    fill_n(1, st);
    chk(32'({st, fill, thf, gpo}), 32'({8'h04, 7'h05, 2'b11}));
    thr = 4'h0;
    fill_n(55, st);
    chk(32'({fill, thf}), 32'({7'h3C, 1'b0}));
    fill_n(4, st);
    chk(32'({st, fill, thf}), 32'({8'h0F, 7'h40, 1'b1}));
    // Drain back to back, then ask once more while empty
    req = 1'b1;
    repeat (64) @(negedge clk_i);
    req = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(32'({exp_q.size(), fill}), 32'h0);
    req = 1'b1;
    @(negedge clk_i);
    req = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(32'(unf), 32'h1);
    pulse(S_ID);
    @(negedge clk_i);
    chk(32'({unf, cwo}), 32'({1'b0, cw}));
    // Plain turn-on and turn-off
    pulse(S_TX);
    measure(TFSC_SETTLE, n);
    chk(n, 1954);
    pulse(S_PK);
    measure(TFSC_TXEND, n);
    chk(n, 32'(per >> 2));
    chk(32'(rs), 32'(TFSC_IDLE));
    // Manual calibration over both settings and pump choices
    for (int k = 0; k < 4; k++)
    begin
      ctest = k[1] ? CAL_TEST_0B : CAL_TEST_09;
      cpen = k[0] ? CP_CAL_ON : CP_CAL_OFF;
      pulse(S_CA);
      measure(TFSC_MCAL, n);
      chk(n, 283);
      measure(TFSC_CAL, n);
      chk(n, cal_len[k]);
    end
    // Calibrate on turn-on, then lock shows on the output
    ctest = CAL_TEST_09;
    cpen = CP_CAL_OFF;
    acal = AUTOCAL_TURNON;
    osel = GPO_SEL_LOCK;
    pulse(S_SY);
    measure(TFSC_SETTLE, n);
    chk(n, 1953);
    measure(TFSC_CAL, n);
    chk(n, 3764);
    repeat (2) @(negedge clk_i);
    chk(32'({rs, lock, gpo, calv == CAL_UNLOCKED}), 32'({TFSC_SYNON, 3'b110}));
    // On-off keying turn-off with calibration after it
    acal = AUTOCAL_TURNOFF;
    pwr = PWR_SEL_OOK;
    pulse(S_TX);
    repeat (3) @(negedge clk_i);
    chk(32'(rs), 32'(TFSC_TX));
    pulse(S_PK);
    measure(TFSC_TXEND, n);
    chk(n, 32'((per >> 2) + (per >> 3)));
    measure(TFSC_CAL, n);
    chk(n, 3764);
    chk(32'({rs, lock}), 32'({TFSC_IDLE, 1'b0}));
    // Forced idle skips the turn-off calibration
    pwr = 3'h0;
    pulse(S_TX);
    measure(TFSC_SETTLE, n);
    chk(n, 1954);
    pulse(S_ID);
    measure(TFSC_TXEND, n);
    chk(n, 32'(per >> 2));
    chk(32'(rs), 32'(TFSC_IDLE));
    // Every fourth automatic turn-off calibrates; two were counted so far
    acal = AUTOCAL_FOURTH;
    for (int k = 0; k < 2; k++)
    begin
      pulse(S_TX);
      measure(TFSC_SETTLE, n);
      chk(n, 1954);
      pulse(S_PK);
      measure(TFSC_TXEND, n);
      chk(32'(rs), 32'(k ? TFSC_CAL : TFSC_IDLE));
    end
    measure(TFSC_CAL, n);
    chk(n, 3764);
    // Power down on select release, wake on select
    pulse(S_PD);
    host.touch();
    repeat (6) @(negedge clk_i);
    chk(32'({rs, pon}), 32'({TFSC_SLEEP, 1'b0}));
    host.touch();
    repeat (4) @(negedge clk_i);
    chk(32'({rs, pon}), 32'({TFSC_IDLE, 1'b1}));
    give_verdict();
  end
endmodule
`default_nettype wire
